/* File: core/hmdp_port.sv */
// Host memory port: latch, overlay, synchronised memory access and host boot
module hmdp_port
  import hmdp_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // Host pins, active low strobes except the active high address latch strobe
  input  wire logic                 host_port_select_n_i,
  input  wire logic                 host_address_latch_strobe_i,
  input  wire logic                 host_read_strobe_n_i,
  input  wire logic                 host_write_strobe_n_i,
  input  wire logic [15:0]          host_address_data_bus_i,
  output logic      [15:0]          host_address_data_bus_o,
  output logic                      host_address_data_bus_oe_n_o,
  output logic                      host_port_acknowledge_n_o,
  // Boot mode pins
  input  wire logic [2:0]           boot_mode_i,
  output logic                      exec_hold_o,
  // Processor data bus access to the control register
  input  wire logic                 cpu_wr_i,
  input  wire logic                 cpu_rd_i,
  input  wire logic [13:0]          cpu_addr_i,
  input  wire logic [15:0]          cpu_wdata_i,
  output logic      [15:0]          cpu_rdata_o,
  output logic      [7:0]           memory_overlay_select_o,
  // On-chip memory port, one cycle access
  output logic                      mem_req_o,
  output logic                      mem_we_o,
  output logic                      mem_program_space_o,
  output logic      [13:0]          mem_addr_o,
  output logic      [23:0]          mem_wdata_o,
  input  wire logic [23:0]          mem_rdata_i
);
  import hmdp_pkg::*;

  // ************************************************************
  // Input synchronisation
  // ************************************************************
  logic [3:0]  strb_s;
  logic [15:0] bus_s;
  logic [2:0]  mode_s;
  hmdp_sync #(.W(4)) u_strb (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i ({~host_port_select_n_i, host_address_latch_strobe_i,
               ~host_read_strobe_n_i, ~host_write_strobe_n_i}),
    .sync_o  (strb_s)
  );
  hmdp_sync #(.W(19)) u_bus (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i ({boot_mode_i, host_address_data_bus_i}),
    .sync_o  ({mode_s, bus_s})
  );

  logic sel, ale, rd, wr;
  assign sel = strb_s[3];
  assign ale = strb_s[2];
  assign rd  = strb_s[1];
  assign wr  = strb_s[0];

  // Edge history of synchronised strobes
  logic ale_d_reg, sel_d_reg, rd_d_reg, wr_d_reg;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ale_d_reg <= 1'b0;
      sel_d_reg <= 1'b0;
      rd_d_reg  <= 1'b0;
      wr_d_reg  <= 1'b0;
    end else begin
      ale_d_reg <= ale;
      sel_d_reg <= sel;
      rd_d_reg  <= rd && sel;
      wr_d_reg  <= wr && sel;
    end
  end

  // Latch fires when the address strobe falls with select held, or select
  // drops while the address strobe is still high
  logic latch_ev, rd_ev, wr_ev;
  assign latch_ev = (ale_d_reg && !ale && sel_d_reg) ||
                    (sel_d_reg && !sel && ale_d_reg);
  assign rd_ev    = rd && sel && !rd_d_reg;
  assign wr_ev    = wr && sel && !wr_d_reg;

  // ************************************************************
  // Control register and overlay
  // ************************************************************
  logic [13:0] addr_reg;
  logic        space_reg;
  logic [7:0]  ovl_reg;
  logic        half_reg;
  logic [7:0]  upper_reg;
  hmdp_state_e state_reg;
  logic        cpu_ctrl_hit;
  logic        advance;
  assign cpu_ctrl_hit = (cpu_addr_i == CTRL_REG_ADDR);

  // Host latch, taken only when idle, wins over processor write when both happen together
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      addr_reg  <= CTRL_RESET;
      space_reg <= 1'b0;
      ovl_reg   <= OVL_RESET;
    end else if (latch_ev && state_reg == HMDP_IDLE) begin
      if (bus_s[CTRL_OVL_BIT]) begin
        ovl_reg <= bus_s[7:0];
      end else begin
        addr_reg  <= bus_s[13:0];
        space_reg <= bus_s[CTRL_SPACE_BIT];
      end
    end else if (cpu_wr_i && cpu_ctrl_hit) begin
      if (cpu_wdata_i[CTRL_OVL_BIT]) begin
        ovl_reg <= cpu_wdata_i[7:0];
      end else begin
        addr_reg  <= cpu_wdata_i[13:0];
        space_reg <= cpu_wdata_i[CTRL_SPACE_BIT];
      end
    end else if (advance) begin
      addr_reg <= addr_reg + 14'h0001;
    end
  end

  // Processor read-back of the control register; host has no such path
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_rdata_o <= 16'h0000;
    end else if (cpu_rd_i && cpu_ctrl_hit) begin
      cpu_rdata_o <= {1'b0, space_reg, addr_reg};
    end
  end
  assign memory_overlay_select_o = ovl_reg;

  // ************************************************************
  // Access sequencer
  // ************************************************************
  logic        pend_we_reg;
  logic [15:0] pend_data_reg;
  logic        is_ctrl_area;
  // Registers sit at and above the control address in data space
  assign is_ctrl_area = !space_reg && (addr_reg >= CTRL_REG_FIRST);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg     <= HMDP_IDLE;
      pend_we_reg   <= 1'b0;
      pend_data_reg <= 16'h0000;
    end else begin
      case (state_reg)
        HMDP_IDLE: begin
          if (rd_ev || wr_ev) begin
            state_reg     <= HMDP_SYNC;
            pend_we_reg   <= wr_ev;
            pend_data_reg <= bus_s;
          end
        end
        HMDP_SYNC: state_reg <= HMDP_ACC;
        HMDP_ACC:  state_reg <= HMDP_WAIT;
        HMDP_WAIT: begin
          if (!(rd || wr)) begin
            state_reg <= HMDP_IDLE;
          end
        end
        default:   state_reg <= HMDP_IDLE;
      endcase
    end
  end

  // Program words use two transfers: reads give upper 16 bits then low byte, writes take upper byte then low 16 bits
  logic do_mem;
  assign do_mem  = (state_reg == HMDP_ACC);
  assign advance = do_mem && (!space_reg || half_reg);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      half_reg  <= 1'b0;
      upper_reg <= 8'h00;
    end else if (latch_ev || (cpu_wr_i && cpu_ctrl_hit)) begin
      half_reg <= 1'b0;
    end else if (do_mem && space_reg) begin
      half_reg <= !half_reg;
      if (!half_reg) begin
        upper_reg <= pend_data_reg[15:8];
      end
    end
  end

  // Memory strobes, registered data
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mem_req_o           <= 1'b0;
      mem_we_o            <= 1'b0;
      mem_program_space_o <= 1'b0;
      mem_addr_o          <= 14'h0000;
      mem_wdata_o         <= 24'h000000;
    end else begin
      // Upper half of a program write only stages data
      mem_req_o <= (state_reg == HMDP_SYNC) &&
                   !(pend_we_reg && is_ctrl_area) &&
                   !(space_reg && !half_reg && pend_we_reg);
      mem_we_o            <= pend_we_reg;
      mem_program_space_o <= space_reg;
      mem_addr_o          <= addr_reg;
      mem_wdata_o         <= space_reg ? {upper_reg, pend_data_reg}
                                       : {8'h00, pend_data_reg};
    end
  end

  // Read data back to the host
  logic [15:0] rdata_reg;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 16'h0000;
    end else if (do_mem && !pend_we_reg) begin
      if (space_reg && !half_reg) begin
        rdata_reg <= mem_rdata_i[23:8];
      end else if (space_reg) begin
        rdata_reg <= {8'h00, mem_rdata_i[7:0]};
      end else begin
        rdata_reg <= mem_rdata_i[15:0];
      end
    end
  end
  assign host_address_data_bus_o      = rdata_reg;
  assign host_address_data_bus_oe_n_o = !(state_reg == HMDP_WAIT && rd && sel);

  // Acknowledge, low active: ready only when idle
  assign host_port_acknowledge_n_o = (state_reg != HMDP_IDLE);

  // ************************************************************
  // Host boot hold
  // ************************************************************
  // Mode pins pass two reset-cleared flops, so they are only valid at the
  // third edge after release; sampling earlier would always read zero
  logic [1:0] boot_cnt_reg;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      boot_cnt_reg <= 2'h0;
      exec_hold_o  <= 1'b0;
    end else if (boot_cnt_reg != 2'h3) begin
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
      if (boot_cnt_reg == 2'h2) begin
        exec_hold_o <= (mode_s == BOOT_HOST_MODE);
      end
    end else if (mem_req_o && mem_we_o && mem_program_space_o &&
                 mem_addr_o == 14'h0000) begin
      exec_hold_o <= 1'b0;
    end
  end
endmodule : hmdp_port

/* File: core/hmdp_pkg.sv */
// Constants and types of the host memory port
// How it works
// - Host moves memory words, one cycle each
// - Control registers unreachable from host writes
// - Bit15 set: bits 7:0 overlay, 14:8 zero
// - Bit15 clear: 13:0 address, 14 space
// - One 16-bit muxed bus, 24-bit words
// - Strobes asynchronous, accepted at full speed
// - Address auto-increments after each data transfer, and after the second transfer of a program word
// - Latch on address strobe or select edge
// - One sync cycle, then one access cycle
// - Bit15 set loads overlay register instead
// - Control register mapped at data address 0x3FE0
// - Latched start address not host readable
// - Processor may write the start address
// - Mode pins C1 B0 A1 select host boot
// - Execution held until program word 0 written
package hmdp_pkg;
  localparam int          ADDR_W         = 14;
  localparam int          DATA_W         = 16;
  localparam int          PWORD_W        = 24;
  localparam int          OVL_W          = 8;
  localparam int          CTRL_OVL_BIT   = 15;
  localparam int          CTRL_SPACE_BIT = 14;
  localparam logic [13:0] CTRL_REG_ADDR  = 14'h3FE0;
  localparam logic [13:0] CTRL_RESET     = 14'h0000;
  localparam logic [7:0]  OVL_RESET      = 8'h00;
  localparam logic [2:0]  BOOT_HOST_MODE = 3'h5;
  localparam logic [13:0] CTRL_REG_FIRST = 14'h3FE0;
  typedef enum logic [1:0] {
    HMDP_IDLE  = 2'b00,
    HMDP_SYNC  = 2'b01,
    HMDP_ACC   = 2'b10,
    HMDP_WAIT  = 2'b11
  } hmdp_state_e;
endpackage : hmdp_pkg

/* File: core/hmdp_sync.sv */
// Two-stage synchroniser for asynchronous host strobes
module hmdp_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;
  // First stage feeds only the second stage
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule : hmdp_sync

/* File: bench/hmdp_port_sva.sv */
// Assertion checker for the host memory port, bound to its top module
module hmdp_port_sva
  import hmdp_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        host_port_select_n_i,
  input wire logic        host_address_latch_strobe_i,
  input wire logic        host_port_acknowledge_n_o,
  input wire logic        exec_hold_o,
  input wire logic        cpu_wr_i,
  input wire logic [13:0] cpu_addr_i,
  input wire logic [15:0] cpu_wdata_i,
  input wire logic [7:0]  memory_overlay_select_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic        mem_program_space_o,
  input wire logic [13:0] mem_addr_o
);
  // ****************
  // Port properties
  // ****************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic boot_wr;
  // Program word 0 write is what frees the processor
  assign boot_wr = mem_req_o & mem_we_o & mem_program_space_o & (mem_addr_o == 14'h0000);
  a_req_one_cycle: assert property (mem_req_o |=> !mem_req_o)
    else $error("memory request longer than one cycle");
  a_req_while_busy: assert property (mem_req_o |-> host_port_acknowledge_n_o)
    else $error("ready shown during memory access");
  a_sync_then_req: assert property (mem_req_o |-> $past(host_port_acknowledge_n_o) && !$past(host_port_acknowledge_n_o, 2))
    else $error("access not one cycle after sync");
  a_busy_span: assert property (
    $rose(host_port_acknowledge_n_o) |-> host_port_acknowledge_n_o[*3])
    else $error("busy shorter than sync, access and wait");
  a_req_selected: assert property (mem_req_o |-> !host_port_select_n_i)
    else $error("access without host select");
  a_ctrl_guarded: assert property (
    mem_req_o && mem_we_o && !mem_program_space_o |-> mem_addr_o < CTRL_REG_FIRST)
    else $error("host write reached control area");
  a_hold_cause: assert property ($fell(exec_hold_o) |-> $past(boot_wr) || $past(boot_wr, 2))
    else $error("hold released without word 0 write");
  a_cpu_overlay: assert property (
    cpu_wr_i && cpu_addr_i == CTRL_REG_ADDR && cpu_wdata_i[15] && !host_address_latch_strobe_i
    |=> memory_overlay_select_o == $past(cpu_wdata_i[7:0]))
    else $error("processor overlay write lost");
  cover property (mem_req_o && mem_we_o && mem_program_space_o);
  cover property (mem_req_o && !mem_we_o);
  cover property ($fell(exec_hold_o));
endmodule : hmdp_port_sva

bind hmdp_port hmdp_port_sva hmdp_port_sva_i (.clock_i, .rst_i, .host_port_select_n_i,
  .host_address_latch_strobe_i, .host_port_acknowledge_n_o, .exec_hold_o, .cpu_wr_i,
  .cpu_addr_i, .cpu_wdata_i, .memory_overlay_select_o, .mem_req_o, .mem_we_o,
  .mem_program_space_o, .mem_addr_o);

/* File: bench/hmdp_host.sv */
// Host processor model driving the asynchronous port pins
module hmdp_host (
  input  wire logic        clock_i,
  input  wire logic        ack_n_i,
  input  wire logic [15:0] bus_i,
  output logic             sel_n_o,
  output logic             ale_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic [15:0]      bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Host cycles
  // ****************
  // Idle pins at time zero
  initial begin
    sel_n_o = 1'b1;
    ale_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    bus_o = 16'h0000;
  end
  // Bounded wait for ready; after 40 cycles the host goes on even if the port is still busy
  task automatic wait_ready();
    for (int i = 0; i < 40 && ack_n_i !== 1'b0; i++) @(negedge clock_i);
  endtask : wait_ready
  // Latch cycle, bus steady three cycles each side of the strobe fall
  task automatic latch(input logic [15:0] val);
    wait_ready();
    bus_o = val;
    sel_n_o = 1'b0;
    ale_o = 1'b1;
    repeat (3) @(negedge clock_i);
    ale_o = 1'b0;
    repeat (3) @(negedge clock_i);
    sel_n_o = 1'b1;
    bus_o = ~val; // Released bus must not keep looking valid
  endtask : latch
  // One data transfer; strobes held long enough for sync plus access
  task automatic xfer(input logic we, input logic [15:0] wd, output logic [15:0] rd);
    wait_ready();
    bus_o = we ? wd : ~bus_o;
    sel_n_o = 1'b0;
    wr_n_o = !we;
    rd_n_o = we;
    repeat (8) @(negedge clock_i);
    rd = bus_i;
    sel_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    bus_o = ~bus_o;
    repeat (2) @(negedge clock_i);
  endtask : xfer
endmodule : hmdp_host

/* File: bench/tb.sv */
// Testbench of the host memory port with host model and memory stub
module tb;
  import hmdp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, rst_i, host_port_select_n_i, host_address_latch_strobe_i;
  logic        host_read_strobe_n_i, host_write_strobe_n_i, host_address_data_bus_oe_n_o;
  logic        host_port_acknowledge_n_o, exec_hold_o, cpu_wr_i, cpu_rd_i;
  logic        mem_req_o, mem_we_o, mem_program_space_o, wr_ps;
  logic [15:0] host_address_data_bus_i, host_address_data_bus_o, host_drive, r;
  logic [15:0] cpu_wdata_i, cpu_rdata_o;
  logic [13:0] cpu_addr_i, mem_addr_o, wr_addr;
  logic [23:0] mem_wdata_o, mem_rdata_i, wr_data;
  logic [7:0]  memory_overlay_select_o;
  logic [2:0]  boot_mode_i;
  int          n_errors = 0, n_compared = 0, wr_cnt = 0, c;
  // ****************
  // Harness
  // ****************
  hmdp_port hmdp_port_i (.*);
  hmdp_host hmdp_host_i (.clock_i, .ack_n_i(host_port_acknowledge_n_o),
    .bus_i(host_address_data_bus_i), .sel_n_o(host_port_select_n_i),
    .ale_o(host_address_latch_strobe_i), .rd_n_o(host_read_strobe_n_i),
    .wr_n_o(host_write_strobe_n_i), .bus_o(host_drive));
  // Shared bus: device level while it drives, host level otherwise
  assign host_address_data_bus_i = host_address_data_bus_oe_n_o ? host_drive
                                                                : host_address_data_bus_o;
  assign mem_rdata_i = {8'hA5, 2'h0, mem_addr_o}; // Read pattern tied to address
  always #5 clock_i = ~clock_i;
  // Record each memory write the port issues
  always @(posedge clock_i) begin
    if (mem_req_o && mem_we_o) begin
      wr_cnt++;
      {wr_ps, wr_addr, wr_data} = {mem_program_space_o, mem_addr_o, mem_wdata_o};
    end
  end
  // Last write in control word layout; data space upper byte is don't care
  function automatic logic [39:0] rec();
    return {1'b0, wr_ps, wr_addr, wr_ps ? wr_data[23:16] : 8'h00, wr_data[15:0]};
  endfunction : rec
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cpu_acc(input logic wr, input logic [15:0] d);
    cpu_wr_i = wr;
    cpu_rd_i = !wr;
    cpu_addr_i = CTRL_REG_ADDR;
    cpu_wdata_i = d;
    @(negedge clock_i);
    cpu_wr_i = 1'b0;
    cpu_rd_i = 1'b0;
    @(negedge clock_i);
  endtask : cpu_acc
  task automatic t_data();
    hmdp_host_i.latch(16'h0100);
    hmdp_host_i.xfer(1'b1, 16'h1234, r);
    chk(rec(), 40'h0100001234);
    hmdp_host_i.xfer(1'b1, 16'hABCD, r);
    chk(rec(), 40'h010100ABCD);
  endtask : t_data
  task automatic t_prog();
    c = wr_cnt;
    hmdp_host_i.latch(16'h4010);
    hmdp_host_i.xfer(1'b1, 16'h1234, r);
    chk(40'(wr_cnt - c), 40'h0);
    hmdp_host_i.xfer(1'b1, 16'h3456, r);
    chk(rec(), 40'h4010123456);
    hmdp_host_i.xfer(1'b0, 16'h0000, r);
    chk({24'h0, r}, 40'hA500);
    hmdp_host_i.xfer(1'b0, 16'h0000, r);
    chk({32'h0, r[7:0]}, 40'h11);
  endtask : t_prog
  task automatic t_ctrl();
    c = wr_cnt;
    hmdp_host_i.latch(16'h3FE0);
    hmdp_host_i.xfer(1'b1, 16'h5555, r);
    chk(40'(wr_cnt - c), 40'h0);
    hmdp_host_i.latch(16'h8005);
    chk(40'(memory_overlay_select_o), 40'h05);
  endtask : t_ctrl
  task automatic t_cpu();
    cpu_acc(1'b1, 16'h0020);
    cpu_acc(1'b0, 16'h0000);
    chk(40'(cpu_rdata_o), 40'h0020);
    cpu_acc(1'b1, 16'h80A7);
    chk(40'(memory_overlay_select_o), 40'hA7);
    hmdp_host_i.xfer(1'b1, 16'h7777, r);
    chk(rec(), 40'h0020007777);
  endtask : t_cpu
  task automatic t_boot();
    chk(40'(exec_hold_o), 40'h1);
    hmdp_host_i.latch(16'h4000);
    hmdp_host_i.xfer(1'b1, 16'h0000, r);
    chk(40'(exec_hold_o), 40'h1);
    hmdp_host_i.xfer(1'b1, 16'h0077, r);
    chk(40'(exec_hold_o), 40'h0);
  endtask : t_boot
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // Main sequence; host boot mode is set before reset ends
  initial begin
    {clock_i, rst_i, cpu_wr_i, cpu_rd_i, cpu_addr_i, cpu_wdata_i} = {2'b01, 32'h0};
    boot_mode_i = 3'h5;
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clock_i);
    t_data();
    t_prog();
    t_ctrl();
    t_cpu();
    t_boot();
    final_report();
  end
  // Watchdog, far beyond the about 150 cycles the scenarios need
  initial begin
    repeat (5000) @(posedge clock_i);
    n_errors++;
    final_report();
  end
endmodule : tb
